/* hw/cdi_defines.vh */
// Purpose: Constants for the coupler diagnostics and image shaping block
// Assumes: Byte addresses on APB, 32-bit data
// Notes: Guarded header, definitions only
`ifndef CDI_DEFINES_VH
`define CDI_DEFINES_VH
`define CDI_OFF_PRM1 12'h000
`define CDI_OFF_PRM7 12'h004
`define CDI_OFF_PRM9 12'h008
`define CDI_OFF_PRM11 12'h00c
`define CDI_OFF_CHSTAT 12'h010
`define CDI_OFF_CHKIND 12'h014
`define CDI_OFF_DIGDIAG 12'h018
`define CDI_OFF_PEND 12'h01c
`define CDI_OFF_DIAGINFO 12'h020
`define CDI_OFF_MODDESC 12'h024
`define CDI_OFF_IMAGE 12'h028
`define CDI_OFF_IRQ_STAT 12'h02c
`define CDI_OFF_IRQ_CLR 12'h030
`define CDI_OFF_IRQ_EN 12'h034
`define CDI_OFF_CYCLE 12'h038
`define CDI_BIT_NOCHECK 0
`define CDI_BIT_DIAG_EN 1
`define CDI_BIT_DIGNOMAP 4
`define CDI_BIT_COMPLEX 2
`define CDI_BIT_ALIGN 5
`define CDI_BIT_STAT_DIAG 6
`define CDI_BIT_STAT_EXC 3
`define CDI_MAXLEN_RST 8'h40
`define CDI_DIAG_BASE 8'h10
`define CDI_NCH 8
`define CDI_NMOD 4
`define CDI_IRQ_NEWDIAG 0
`define CDI_IRQ_OVF 1
`define CDI_IRQ_W 2
`endif

/* hw/cdi_top.v */
// Purpose: Terminal diagnostics change detection and process image shaping
// Assumes: Single clock pclk, async active-low presetn, APB slave
// Notes: Up to 8 channels, 4 complex module descriptors
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "cdi_defines.vh"
module cdi_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire irq,
  output reg extended_diag_overflow_flag,
  output reg new_diag,
  output reg [7:0] dig_in_bits,
  output reg [7:0] dig_out_bits,
  output reg [7:0] in_len,
  output reg [7:0] out_len,
  output reg layout_error
);
  // APB decode, zero wait states
  wire wr = psel & penable & pwrite;
  wire rd_sel = psel & ~pwrite;
  assign pready = 1'b1;
  // Parameter bytes from the user parameter block
  reg [7:0] prm1_reg;
  reg [7:0] prm7_reg;
  reg [7:0] prm9_reg;
  reg [7:0] prm11_reg;
  // Channel kinds and watched diagnostic state
  reg [7:0] chexc_reg;
  reg [7:0] chdig_reg;
  reg [7:0] chcpx_reg;
  reg [7:0] digdiag_reg;
  reg [7:0] last_reg;
  reg [7:0] pend_reg;
  reg [7:0] pend_hold_reg;
  reg [31:0] moddesc_reg;
  reg [15:0] cfg_len_reg;
  wire [1:0] irq_stat_reg;
  reg [1:0] irq_en_reg;
  reg [15:0] cycle_reg;
  reg [15:0] cyc_mark_reg;
  reg rel_pend_reg;
  reg [7:0] maxlen_reg;
  wire [7:0] chstat_in;
  reg [63:0] chstat_bits;
  // Diagnosis and mapping controls
  wire diag_en = prm7_reg[`CDI_BIT_DIAG_EN];
  wire no_check = prm1_reg[`CDI_BIT_NOCHECK];
  wire cpx_map = prm9_reg[`CDI_BIT_COMPLEX];
  wire align_en = prm9_reg[`CDI_BIT_ALIGN];
  wire dig_nomap = diag_en & prm7_reg[`CDI_BIT_DIGNOMAP];
  reg [7:0] watch;
  integer i;
  always @* begin
    for (i = 0; i < `CDI_NCH; i = i + 1) begin
      if (chdig_reg[i])
        watch[i] = digdiag_reg[i];
      else if (chexc_reg[i])
        watch[i] = chstat_in[i];
      else
        watch[i] = chstat_in[i];
    end
  end
  // Per-channel status bit pick: exception bit 3, else bit 6
  genvar g;
  generate
    for (g = 0; g < `CDI_NCH; g = g + 1) begin : g_pick
      cdi_chan_pick u_cdi_chan_pick (
        .stat(chstat_bits[g*8 +: 8]),
        .exc(chexc_reg[g]),
        .pick(chstat_in[g])
      );
    end
  endgenerate
  // Change detect against the last inspection
  wire [7:0] active = chcpx_reg | chdig_reg;
  wire [7:0] changed = (watch ^ last_reg) & active &
    {8{diag_en}};
  wire ev_change = |changed;
  reg [3:0] npend;
  always @* begin
    npend = 4'h0;
    for (i = 0; i < `CDI_NCH; i = i + 1)
      npend = npend + {3'b000, pend_reg[i]};
  end
  wire [7:0] diag_len = `CDI_DIAG_BASE + {3'b000, npend, 1'b0};
  // Overflow against the configured maximum
  wire ovf_now = diag_en & (diag_len > maxlen_reg);
  // Legal maximum lengths only; others fall back to default
  wire [7:0] maxlen_w = pwdata[7:0];
  wire maxlen_ok = (maxlen_w[2:0] == 3'b000) && (maxlen_w >= 8'h10) &&
    (maxlen_w <= 8'h40);
  // Parameter and descriptor writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prm1_reg <= 8'h00;
      prm7_reg <= 8'h00;
      prm9_reg <= 8'h00;
      prm11_reg <= `CDI_MAXLEN_RST;
      maxlen_reg <= `CDI_MAXLEN_RST;
      chexc_reg <= 8'h00;
      chdig_reg <= 8'h00;
      chcpx_reg <= 8'h00;
      digdiag_reg <= 8'h00;
      chstat_bits <= 64'h0;
      moddesc_reg <= 32'h0;
      cfg_len_reg <= 16'h0;
      irq_en_reg <= 2'b00;
    end else if (wr) begin
      case (paddr)
        `CDI_OFF_PRM1: prm1_reg <= pwdata[7:0];
        `CDI_OFF_PRM7: prm7_reg <= pwdata[7:0];
        `CDI_OFF_PRM9: prm9_reg <= pwdata[7:0];
        `CDI_OFF_PRM11: begin
          prm11_reg <= pwdata[7:0];
          maxlen_reg <= maxlen_ok ? maxlen_w : `CDI_MAXLEN_RST;
        end
        `CDI_OFF_CHSTAT: chstat_bits[{pwdata[26:24], 3'b000} +: 8] <=
          pwdata[7:0];
        `CDI_OFF_CHKIND: begin
          chcpx_reg <= pwdata[7:0];
          chexc_reg <= pwdata[15:8];
          chdig_reg <= pwdata[23:16];
        end
        `CDI_OFF_DIGDIAG: digdiag_reg <= pwdata[7:0];
        `CDI_OFF_MODDESC: moddesc_reg <= pwdata;
        `CDI_OFF_IMAGE: cfg_len_reg <= pwdata[15:0];
        `CDI_OFF_IRQ_EN: irq_en_reg <= pwdata[1:0];
        default: ;
      endcase
    end
  end
  // Change tracking, pending set and process-data cycle stamping
  wire cyc_tick = wr && (paddr == `CDI_OFF_CYCLE);
  // Pending clear from software
  wire [7:0] pend_clr = (wr && (paddr == `CDI_OFF_PEND)) ?
    pwdata[7:0] : 8'h00;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg <= 8'h00;
      pend_reg <= 8'h00;
      pend_hold_reg <= 8'h00;
      cycle_reg <= 16'h0;
      cyc_mark_reg <= 16'h0;
      rel_pend_reg <= 1'b0;
      new_diag <= 1'b0;
      extended_diag_overflow_flag <= 1'b0;
    end else begin
      last_reg <= watch;
      if (cyc_tick)
        cycle_reg <= cycle_reg + 16'h1;
      if (ev_change) begin
        pend_hold_reg <= pend_hold_reg | changed;
        cyc_mark_reg <= cycle_reg;
        rel_pend_reg <= 1'b1;
      end
      // Release only after a later process-data cycle
      new_diag <= 1'b0;
      if (rel_pend_reg && !ev_change && (cycle_reg != cyc_mark_reg)) begin
        pend_reg <= (pend_reg & ~pend_clr) | pend_hold_reg;
        pend_hold_reg <= 8'h00;
        rel_pend_reg <= 1'b0;
        new_diag <= 1'b1;
      end else
        pend_reg <= pend_reg & ~pend_clr;
      if (!diag_en)
        pend_reg <= 8'h00;
      extended_diag_overflow_flag <= ovf_now;
    end
  end
  // Sticky interrupt status, set wins over clear
  wire [1:0] irq_set = {ovf_now, new_diag};
  wire [1:0] irq_clr = (wr && (paddr == `CDI_OFF_IRQ_CLR)) ?
    pwdata[1:0] : 2'b00;
  genvar s;
  generate
    for (s = 0; s < `CDI_IRQ_W; s = s + 1) begin : g_irq
      cdi_sticky_bit u_cdi_sticky_bit (
        .pclk(pclk),
        .presetn(presetn),
        .set(irq_set[s]),
        .clr(irq_clr[s]),
        .stat(irq_stat_reg[s])
      );
    end
  endgenerate
  assign irq = |(irq_stat_reg & irq_en_reg);
  // Image length builder: complex modules first, then digital
  reg [7:0] a_in;
  reg [7:0] a_out;
  reg [7:0] ml;
  reg [7:0] mo;
  reg [1:0] mk;
  reg [7:0] din_bytes;
  reg [7:0] dout_bytes;
  integer m;
  always @* begin
    a_in = 8'h00;
    a_out = 8'h00;
    for (m = 0; m < `CDI_NMOD; m = m + 1) begin
      ml = {4'h0, moddesc_reg[m*8 +: 4]};
      mk = moddesc_reg[m*8+4 +: 2];
      mo = ml;
      if (ml != 8'h00) begin
        if (cpx_map) begin
          mo = ml + 8'h01;
          if (align_en && a_in[0] && (mo > 8'h01))
            a_in = a_in + 8'h01;
          if (align_en && a_out[0] && (mo > 8'h01))
            a_out = a_out + 8'h01;
          a_in = a_in + mo;
          a_out = a_out + mo;
        end else if (mk[0]) begin
          if (align_en && a_out[0] && (ml > 8'h01))
            a_out = a_out + 8'h01;
          a_out = a_out + ml;
        end else begin
          if (align_en && a_in[0] && (ml > 8'h01))
            a_in = a_in + 8'h01;
          a_in = a_in + ml;
        end
      end
    end
    din_bytes = 8'h00;
    dout_bytes = 8'h00;
    for (m = 0; m < `CDI_NCH; m = m + 1) begin
      if (chdig_reg[m]) begin
        if (dig_nomap) begin
          din_bytes = din_bytes + (chexc_reg[m] ? 8'h00 : 8'h02);
          dout_bytes = dout_bytes + (chexc_reg[m] ? 8'h04 : 8'h00);
        end else begin
          din_bytes = din_bytes + 8'h04;
          dout_bytes = dout_bytes + 8'h04;
        end
      end
    end
  end
  // Lengths registered for the image
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_len <= 8'h00;
      out_len <= 8'h00;
      dig_in_bits <= 8'h00;
      dig_out_bits <= 8'h00;
      layout_error <= 1'b0;
    end else begin
      dig_in_bits <= din_bytes;
      dig_out_bits <= dout_bytes;
      if (no_check) begin
        in_len <= cfg_len_reg[7:0];
        out_len <= cfg_len_reg[15:8];
        layout_error <= 1'b0;
      end else begin
        in_len <= a_in + {3'b000, din_bytes[7:3]} +
          {7'h00, |din_bytes[2:0]};
        out_len <= a_out + {3'b000, dout_bytes[7:3]} +
          {7'h00, |dout_bytes[2:0]};
        layout_error <= (cfg_len_reg != 16'h0) &&
          (cfg_len_reg != {out_len, in_len});
      end
    end
  end
  // Register read-back
  always @* begin
    prdata = 32'h0;
    if (rd_sel) begin
      case (paddr)
        `CDI_OFF_PRM1: prdata = {24'h0, prm1_reg};
        `CDI_OFF_PRM7: prdata = {24'h0, prm7_reg};
        `CDI_OFF_PRM9: prdata = {24'h0, prm9_reg};
        `CDI_OFF_PRM11: prdata = {16'h0, maxlen_reg, prm11_reg};
        `CDI_OFF_CHKIND: prdata = {8'h0, chdig_reg, chexc_reg, chcpx_reg};
        `CDI_OFF_DIGDIAG: prdata = {24'h0, digdiag_reg};
        `CDI_OFF_PEND: prdata = {8'h0, diag_len, pend_hold_reg, pend_reg};
        `CDI_OFF_DIAGINFO: prdata = {16'h0, 7'h00,
          extended_diag_overflow_flag, diag_len};
        `CDI_OFF_MODDESC: prdata = moddesc_reg;
        `CDI_OFF_IMAGE: prdata = {out_len, in_len, cfg_len_reg};
        `CDI_OFF_IRQ_STAT: prdata = {30'h0, irq_stat_reg};
        `CDI_OFF_IRQ_EN: prdata = {30'h0, irq_en_reg};
        `CDI_OFF_CYCLE: prdata = {16'h0, cycle_reg};
        default: prdata = 32'h0;
      endcase
    end
  end
  assign pslverr = 1'b0;
endmodule // cdi_top

// Watched status bit of one channel: exception kinds use the other bit
module cdi_chan_pick #(
  parameter DIAG_BIT = `CDI_BIT_STAT_DIAG,
  parameter EXC_BIT = `CDI_BIT_STAT_EXC
) (
  input wire [7:0] stat,
  input wire exc,
  output wire pick
);
  assign pick = exc ? stat[EXC_BIT] : stat[DIAG_BIT];
endmodule // cdi_chan_pick

// One sticky status bit; the event wins over a clear in the same cycle
module cdi_sticky_bit (
  input wire pclk,
  input wire presetn,
  input wire set,
  input wire clr,
  output reg stat
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      stat <= 1'b0;
    else if (set)
      stat <= 1'b1;
    else if (clr)
      stat <= 1'b0;
  end
endmodule // cdi_sticky_bit

/* verification/cdi_chk_assertions.sv */
// Purpose: Port assertions for cdi_top
// Assumes: Zero-wait APB slave, one clock
// Notes: Bound to every cdi_top
`timescale 1ns/10ps
`include "cdi_defines.vh"
module cdi_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire new_diag,
  input wire extended_diag_overflow_flag,
  input wire [7:0] dig_in_bits,
  input wire [7:0] dig_out_bits,
  input wire [7:0] in_len,
  input wire [7:0] out_len,
  input wire layout_error
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr_any = psel & penable & pwrite;
  wire wr_cyc = wr_any & (paddr == `CDI_OFF_CYCLE);
  sequence s_nd_pulse;
    new_diag ##1 !new_diag;
  endsequence
  sequence s_recent_wr;
    $past(wr_any) || $past(wr_any, 2) || $past(wr_any, 3);
  endsequence
  property p_rdy;
    pready && !pslverr;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready low or pslverr high");
  property p_idle;
    !psel |-> prdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data while idle");
  property p_nd_pulse;
    $rose(new_diag) |-> s_nd_pulse;
  endproperty
  a_nd_pulse: assert property (p_nd_pulse)
    else $error("pulse too long");
  property p_nd_after;
    new_diag |-> $past(wr_cyc, 2);
  endproperty
  a_nd_after: assert property (p_nd_after)
    else $error("early record");
  property p_len;
    $changed({in_len, out_len}) |-> s_recent_wr;
  endproperty
  a_len: assert property (p_len)
    else $error("length moved alone");
  property p_dig;
    $changed({dig_in_bits, dig_out_bits}) |-> s_recent_wr;
  endproperty
  a_dig: assert property (p_dig)
    else $error("bit count moved");
  property p_ovf;
    $rose(extended_diag_overflow_flag) |-> s_recent_wr;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow uncaused");
  property p_lay;
    $changed(layout_error) |-> s_recent_wr;
  endproperty
  a_lay: assert property (p_lay)
    else $error("layout flag moved");
endmodule // cdi_chk
bind cdi_top cdi_chk u_cdi_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .new_diag(new_diag),
  .extended_diag_overflow_flag(extended_diag_overflow_flag),
  .dig_in_bits(dig_in_bits), .dig_out_bits(dig_out_bits),
  .in_len(in_len), .out_len(out_len), .layout_error(layout_error)
);

/* verification/cdi_dp_master.sv */
// Purpose: Bus master writing the user parameter block
// Assumes: APB, request held until pready at a rising edge
// Notes: Released write data shows its inverse
`timescale 1ns/10ps
module cdi_dp_master (
  input wire pclk,
  input wire pready,
  input wire [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // Parameter bytes reach the device here
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule // cdi_dp_master

/* verification/cdi_top_tb.sv */
// Purpose: Self-checking bench for cdi_top
// Assumes: 40 MHz pclk, reset held 3 cycles
// Notes: Diagnosis rows in a table, hand tests after
`timescale 1ns/10ps
`include "cdi_defines.vh"
module cdi_top_tb;
  typedef struct packed {
    logic [7:0] p7;
    logic [23:0] kind;
    logic [11:0] a;
    logic [7:0] d;
    logic [7:0] p11;
    logic nd;
    logic ov;
  } cdi_row_t;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, irq, ovf, new_diag, layout_error;
  logic [7:0] dig_in_bits, dig_out_bits, in_len, out_len;
  int error_cnt = 0;
  int tests_run = 0;
  cdi_row_t rows [8];
  always #12.5 pclk = ~pclk;
  cdi_top u_cdi_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .extended_diag_overflow_flag(ovf), .new_diag(new_diag),
    .dig_in_bits(dig_in_bits), .dig_out_bits(dig_out_bits),
    .in_len(in_len), .out_len(out_len), .layout_error(layout_error));
  cdi_dp_master u_cdi_dp_master (.pclk(pclk), .pready(pready),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    u_cdi_dp_master.xfer(1'b1, a, d, q);
    #1;
  endtask
  task rd(input logic [11:0] a);
    u_cdi_dp_master.xfer(1'b0, a, 32'h0, q);
  endtask
  task rst;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  task settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  task end_of_test;
    $display("Mismatches %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #50000;
    error_cnt++;
    end_of_test;
  end
  initial begin
    rows[0] = '{8'h02, 24'h000001, `CDI_OFF_CHSTAT, 8'h40, 8'h40, 1, 0};
    rows[1] = '{8'h02, 24'h000001, `CDI_OFF_CHSTAT, 8'h08, 8'h40, 0, 0};
    rows[2] = '{8'h02, 24'h000101, `CDI_OFF_CHSTAT, 8'h08, 8'h40, 1, 0};
    rows[3] = '{8'h02, 24'h000101, `CDI_OFF_CHSTAT, 8'h40, 8'h40, 0, 0};
    rows[4] = '{8'h02, 24'h010000, `CDI_OFF_DIGDIAG, 8'h01, 8'h40, 1, 0};
    rows[5] = '{8'h00, 24'h000001, `CDI_OFF_CHSTAT, 8'h40, 8'h40, 0, 0};
    rows[6] = '{8'h02, 24'h000001, `CDI_OFF_CHSTAT, 8'h40, 8'h10, 1, 1};
    rows[7] = '{8'h02, 24'h000001, `CDI_OFF_CHSTAT, 8'h40, 8'h11, 1, 0};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk({new_diag, ovf, irq, pready, in_len}, {4'h1, 8'h00});
    foreach (rows[i]) begin
      rst;
      wr(`CDI_OFF_PRM7, rows[i].p7);
      wr(`CDI_OFF_PRM11, rows[i].p11);
      wr(`CDI_OFF_CHKIND, rows[i].kind);
      wr(`CDI_OFF_IRQ_EN, 32'h3);
      wr(rows[i].a, rows[i].d);
      wr(`CDI_OFF_CYCLE, 32'h0);
      @(posedge pclk);
      #1;
      chk(new_diag, rows[i].nd);
      settle;
      chk(ovf, rows[i].ov);
      chk(irq, rows[i].nd | rows[i].ov);
    end
    rst;
    wr(`CDI_OFF_PRM7, 32'h2);
    wr(`CDI_OFF_CHKIND, 32'h1);
    wr(`CDI_OFF_CHSTAT, 32'h40);
    settle;
    chk(new_diag, 1'b0);
    wr(`CDI_OFF_CYCLE, 32'h0);
    settle;
    chk(irq, 1'b0);
    rd(`CDI_OFF_IRQ_STAT);
    chk(q, 32'h1);
    wr(`CDI_OFF_IRQ_EN, 32'h1);
    chk(irq, 1'b1);
    wr(`CDI_OFF_IRQ_CLR, 32'h1);
    rd(`CDI_OFF_IRQ_STAT);
    chk(q, 32'h0);
    chk(irq, 1'b0);
    rd(`CDI_OFF_PEND);
    chk(q, 32'h00120001);
    wr(`CDI_OFF_PEND, 32'h1);
    rd(`CDI_OFF_PEND);
    chk(q, 32'h00100000);
    wr(12'h03c, 32'hffffffff);
    rd(12'h03c);
    chk(q, 32'h0);
    wr(`CDI_OFF_CHKIND, 32'h030000);
    settle;
    chk({dig_in_bits, dig_out_bits}, 16'h0808);
    wr(`CDI_OFF_PRM7, 32'h12);
    wr(`CDI_OFF_CHKIND, 32'h030200);
    settle;
    chk({dig_in_bits, dig_out_bits}, 16'h0204);
    rst;
    wr(`CDI_OFF_PRM1, 32'h1);
    wr(`CDI_OFF_IMAGE, 32'h0305);
    settle;
    chk({in_len, out_len, layout_error}, 17'h0a06);
    rst;
    wr(`CDI_OFF_PRM9, 32'h20);
    wr(`CDI_OFF_MODDESC, 32'h00130201);
    settle;
    chk({in_len, out_len}, 16'h0403);
    wr(`CDI_OFF_PRM9, 32'h04);
    wr(`CDI_OFF_CHKIND, 32'h010000);
    settle;
    chk({in_len, out_len}, 16'h0a0a);
    chk(layout_error, 1'b0);
    wr(`CDI_OFF_IMAGE, 32'h0101);
    settle;
    chk(layout_error, 1'b1);
    end_of_test;
  end
endmodule // cdi_top_tb
